// File: tb/ssc_sensor_model.sv
/*
 Behavioural sensor: counts charge packets that reach the output node of section 0.
 Assumes section 0 runs in the normal direction and that pins come from flops.
*/
`timescale 1ns/100ps
`default_nettype none
module ssc_sensor_model (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire ssc_pkg::ssc_pins_t pins,
   output logic [15:0]             charges
);
   logic       armed;
   logic [2:0] elec_q;
   logic       sw_q;

   // A packet counts only after a reset pulse, so clock edges outside readout do not
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         armed   <= 1'b0;
         charges <= 16'h0000;
         elec_q  <= 3'h0;
         sw_q    <= 1'b0;
      end
      else
      begin
         elec_q <= pins.serial_elec[2:0];
         sw_q   <= pins.summing_well_gate[0];
         if (pins.reset_pulse)
            armed <= 1'b1;
         else if (armed && (pins.output_gate ? (elec_q[1] && !pins.serial_elec[1])
                                             : (sw_q && !pins.summing_well_gate[0])))
         begin
            charges <= charges + 16'h0001;
            armed   <= 1'b0;
         end
      end
   end
endmodule : ssc_sensor_model
`default_nettype wire

// File: tb/ssc_sequencer_tb.sv
/*
 Bench for the sequencer: APB tasks, a pin monitor and frames in each mode.
 Assumes the sensor model counts packets reaching the output node.
*/
`timescale 1ns/100ps
`default_nettype none
module ssc_sequencer_tb;
   logic               clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic [15:0]        charges, base;
   logic [11:0]        e;
   ssc_pkg::ssc_pins_t pins;
   int                 failures, checks, cycles, mode;

   assign e = pins.serial_elec;

   ssc_sequencer uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pins(pins));
   ssc_sensor_model model (.clk(clk), .rst(rst), .pins(pins), .charges(charges));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task end_of_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test

   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // Idle cycle after each transfer keeps psel from being set twice in one step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task frame(input logic [31:0] cfg, input logic [11:0] n, input logic [11:0] px,
              input logic [15:0] exp, input int m);
      mode = m;
      base = charges;
      apb(1'b1, ssc_pkg::REG_CFG, cfg);
      apb(1'b1, ssc_pkg::REG_LINES, {20'h0, n});
      apb(1'b1, ssc_pkg::REG_PIXELS, {20'h0, px});
      apb(1'b1, ssc_pkg::REG_CTRL, 32'h1);
      rd = 32'h1;
      while (rd[0] === 1'b1) apb(1'b0, ssc_pkg::REG_STATUS, 32'h0);
      cmp({16'h0, charges - base}, {16'h0, exp});
      $display("frame mode %0d done", m);
   endtask : frame

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         end_of_test();
      end
      if (!rst)
      begin
         cmp({e[4], e[3], e[5], e[11:6]}, {e[0], e[1], e[2], e[2:0], e[2:0]});
         if (pins.image_phase > 4'h1) cmp(e & ssc_pkg::ELEC12_MASK, ssc_pkg::ELEC12_MASK);
         if (pins.dump_gate) cmp({20'h0, e}, 32'h0);
         if (pins.reset_pulse) cmp({pins.output_gate, pins.summing_well_gate},
            (mode == 2) ? 5'h10 : {1'b0, (mode == 0) ? {4{e[2]}} : 4'hf});
      end
   end

   initial
   begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; failures = 0; checks = 0; cycles = 0; mode = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, ssc_pkg::REG_PIXELS, 32'h0);
      cmp(rd, {20'h0, ssc_pkg::PIXELS_RESET});
      apb(1'b0, 8'h14, 32'h0);
      cmp({err, rd[30:0]}, 32'h80000000);
      $display("registers done");
      frame(32'h00000002, 12'h002, 12'h004, 16'h0008, 0);
      // Two summed groups, then the gate drops once more as the line ends
      frame(32'h00000202, 12'h001, 12'h006, 16'h0003, 1);
      frame(32'h00000012, 12'h001, 12'h004, 16'h0004, 2);
      frame(32'h00010002, 12'h002, 12'h004, 16'h0004, 0);
      end_of_test();
   end
endmodule : ssc_sequencer_tb
`default_nettype wire

// File: verilog/ssc_delay_timer.sv
/*
 Down counter that times one wait of the sequencer.
 Assumes start is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ssc_delay_timer (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [15:0] load,
   output logic             expired
);

   logic [15:0] count;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         count <= 16'h0000;
      else if (start)
         count <= load;
      else if (count != 16'h0000)
         count <= count - 16'h0001;
   end

   // Masked while loading so a stale zero never ends the new wait early
   assign expired = (count == 16'h0000) && !start;

endmodule : ssc_delay_timer
`default_nettype wire

// File: verilog/ssc_phase_map.sv
/*
 Routes the three serial phases onto the electrodes of four register half-sections.
 Assumes dir is stable during a frame.
*/
`timescale 1ns/100ps
`default_nettype none
module ssc_phase_map (
   input  wire logic [2:0]  ph,
   input  wire logic [3:0]  dir,
   output logic      [11:0] elec
);

   // Per section: bit0 electrode 1, bit1 electrode 2, bit2 electrode 3
   always_comb
   begin
      for (int s = 0; s < 4; s++)
      begin
         elec[3*s +: 3] = dir[s] ? {ph[2], ph[0], ph[1]} : {ph[2], ph[1], ph[0]};
      end
   end

endmodule : ssc_phase_map
`default_nettype wire

// File: verilog/ssc_pkg.sv
/*
 Constants, field layouts and carrier types for the sensor serial clock sequencer.
 Assumes a 10 MHz system clock; all sensor delays are counted in its cycles.
*/
`default_nettype none
package ssc_pkg;

   localparam int CLK_NS = 100;

   // Least times round up to whole cycles, never below one
   function automatic int min_cycles(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : min_cycles

   localparam int LINE_XFER_NS   = 45000;
   localparam int IMG_OVERLAP_NS = 5000;
   localparam int SER_TO_IMG_NS  = 5000;
   localparam int IMG_TO_SER_NS  = 5000;
   localparam int SER_PERIOD_NS  = 200;
   localparam int SER_TO_DUMP_NS = 5000;
   localparam int DUMP_TO_SER_NS = 5000;
   localparam int DUMP_WIDTH_NS  = 5000;
   localparam int SER_OVERLAP_NS = 10;
   localparam int RESET_WIDTH_NS = 125;

   localparam logic [15:0] LINE_XFER_CYC   = 16'(min_cycles(LINE_XFER_NS));
   localparam logic [15:0] IMG_OVERLAP_CYC = 16'(min_cycles(IMG_OVERLAP_NS));
   localparam logic [15:0] SER_TO_IMG_CYC  = 16'(min_cycles(SER_TO_IMG_NS));
   localparam logic [15:0] IMG_TO_SER_CYC  = 16'(min_cycles(IMG_TO_SER_NS));
   localparam logic [15:0] SER_PERIOD_CYC  = 16'(min_cycles(SER_PERIOD_NS));
   localparam logic [15:0] SER_TO_DUMP_CYC = 16'(min_cycles(SER_TO_DUMP_NS));
   localparam logic [15:0] DUMP_TO_SER_CYC = 16'(min_cycles(DUMP_TO_SER_NS));
   localparam logic [15:0] DUMP_WIDTH_CYC  = 16'(min_cycles(DUMP_WIDTH_NS));
   localparam logic [15:0] SER_OVERLAP_CYC = 16'(min_cycles(SER_OVERLAP_NS));
   localparam logic [15:0] RESET_WIDTH_CYC = 16'(min_cycles(RESET_WIDTH_NS));

   // One pixel is eight ticks; bit n of a mask is the level in tick n
   localparam logic [2:0] PIX_LAST_TICK = 3'h7;
   localparam logic [7:0] SER_A_MASK    = 8'h0f;
   localparam logic [7:0] SER_B_MASK    = 8'h18;
   localparam logic [7:0] SER_C_MASK    = 8'hf1;
   localparam logic [7:0] RST_M1_MASK   = 8'h60;
   localparam logic [7:0] RST_M2_MASK   = 8'h06;
   localparam logic [11:0] ELEC12_MASK  = 12'h6db;

   // Image phase pattern per step, step 0 in the low nibble
   localparam logic [31:0] IMG_SEQ      = 32'h198c4623;
   localparam logic [3:0]  IMG_REST     = 4'h1;
   localparam logic [2:0]  IMG_LAST     = 3'h7;

   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_CFG       = 8'h04;
   localparam logic [7:0] REG_LINES     = 8'h08;
   localparam logic [7:0] REG_PIXELS    = 8'h0c;
   localparam logic [7:0] REG_STATUS    = 8'h10;

   localparam int CTRL_START_BIT  = 0;
   localparam int CFG_DIR_LSB     = 0;
   localparam int CFG_MODE2_BIT   = 4;
   localparam int CFG_SUM_LSB     = 8;
   localparam int CFG_DUMP_LSB    = 16;
   localparam int STAT_BUSY_BIT   = 0;
   localparam int STAT_LINE_LSB   = 16;

   localparam logic [11:0] LINES_RESET  = 12'h010;
   localparam logic [11:0] PIXELS_RESET = 12'h010;

   typedef enum logic [2:0] {
      SSC_IDLE      = 3'b000,
      SSC_PRE_IMG   = 3'b001,
      SSC_IMG       = 3'b010,
      SSC_POST_IMG  = 3'b011,
      SSC_DUMP_PRE  = 3'b100,
      SSC_DUMP_ON   = 3'b101,
      SSC_DUMP_POST = 3'b110,
      SSC_READ      = 3'b111
   } ssc_state_t;

   typedef struct packed {
      logic [3:0]  image_phase;
      logic [11:0] serial_elec;
      logic [3:0]  summing_well_gate;
      logic        output_gate;
      logic        dump_gate;
      logic        reset_pulse;
   } ssc_pins_t;

   typedef struct packed {
      logic [3:0]  dir;
      logic        mode2;
      logic [7:0]  sum_count;
      logic [11:0] dump_lines;
      logic [11:0] line_count;
      logic [11:0] pixel_count;
   } ssc_cfg_t;

   function automatic logic [3:0] img_pattern(input logic [2:0] step);
      return IMG_SEQ[4*step +: 4];
   endfunction : img_pattern

   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      return (v == 16'hffff) ? v : v + 16'h0001;
   endfunction : sat_inc

endpackage : ssc_pkg
`default_nettype wire

// File: verilog/ssc_sequencer.sv
/*
 Camera timing generator for a four-output image sensor: image and serial clock
 phases, summing well, output gate, dump gate and output reset, under APB control.
 Assumes a 10 MHz clock, an APB master on the same clock, and that the pin bundle
 feeds clock drivers whose edges follow the register outputs.
*/
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ssc_sequencer (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output var ssc_pkg::ssc_pins_t pins
);

   ssc_pkg::ssc_state_t state;
   ssc_pkg::ssc_cfg_t   cfg;
   ssc_pkg::ssc_cfg_t   act;
   ssc_pkg::ssc_pins_t  next_pins;
   logic [2:0]          ph;
   logic [2:0]          next_ph;
   logic [11:0]         next_elec;
   logic [2:0]          step;
   logic [2:0]          tick;
   logic [11:0]         line_idx;
   logic [11:0]         pix_idx;
   logic [7:0]          sum_idx;
   logic                tmr_start;
   logic [15:0]         tmr_load;
   logic                tmr_done;
   logic [31:0]         rd_word;
   logic                addr_hit;
   logic                apb_wr;
   logic                go;
   logic                last_line;
   logic                last_pix;
   logic                sw_level;

   // Register bus: one wait-free access phase, pready from a flop
   always_comb
   begin
      rd_word  = 32'h0000_0000;
      addr_hit = 1'b1;
      if (paddr == ssc_pkg::REG_CTRL)
         rd_word = 32'h0000_0000;
      else if (paddr == ssc_pkg::REG_CFG)
      begin
         rd_word[ssc_pkg::CFG_DIR_LSB +: 4]   = cfg.dir;
         rd_word[ssc_pkg::CFG_MODE2_BIT]      = cfg.mode2;
         rd_word[ssc_pkg::CFG_SUM_LSB +: 8]   = cfg.sum_count;
         rd_word[ssc_pkg::CFG_DUMP_LSB +: 12] = cfg.dump_lines;
      end
      else if (paddr == ssc_pkg::REG_LINES)
         rd_word[11:0] = cfg.line_count;
      else if (paddr == ssc_pkg::REG_PIXELS)
         rd_word[11:0] = cfg.pixel_count;
      else if (paddr == ssc_pkg::REG_STATUS)
      begin
         rd_word[ssc_pkg::STAT_BUSY_BIT]       = (state != ssc_pkg::SSC_IDLE);
         rd_word[ssc_pkg::STAT_LINE_LSB +: 12] = line_idx;
      end
      else
         addr_hit = 1'b0;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         if (psel && !penable)
         begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= !addr_hit;
         end
      end
   end

   assign apb_wr = psel && penable && pready && pwrite && !pslverr;
   assign go     = apb_wr && (paddr == ssc_pkg::REG_CTRL)
                   && pwdata[ssc_pkg::CTRL_START_BIT] && (state == ssc_pkg::SSC_IDLE);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cfg.dir         <= 4'h0;
         cfg.mode2       <= 1'b0;
         cfg.sum_count   <= 8'h00;
         cfg.dump_lines  <= 12'h000;
         cfg.line_count  <= ssc_pkg::LINES_RESET;
         cfg.pixel_count <= ssc_pkg::PIXELS_RESET;
      end
      else if (apb_wr)
      begin
         if (paddr == ssc_pkg::REG_CFG)
         begin
            cfg.dir        <= pwdata[ssc_pkg::CFG_DIR_LSB +: 4];
            cfg.mode2      <= pwdata[ssc_pkg::CFG_MODE2_BIT];
            cfg.sum_count  <= pwdata[ssc_pkg::CFG_SUM_LSB +: 8];
            cfg.dump_lines <= pwdata[ssc_pkg::CFG_DUMP_LSB +: 12];
         end
         else if (paddr == ssc_pkg::REG_LINES)
            cfg.line_count <= pwdata[11:0];
         else if (paddr == ssc_pkg::REG_PIXELS)
            cfg.pixel_count <= pwdata[11:0];
      end
   end

   ssc_delay_timer u_timer (
      .clk     (clk),
      .rst     (rst),
      .start   (tmr_start),
      .load    (tmr_load),
      .expired (tmr_done)
   );

   assign last_line = (line_idx == act.line_count - 12'h001);
   assign last_pix  = (pix_idx == act.pixel_count - 12'h001);

   // Frame sequence; every wait is a loaded count of system clocks
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state     <= ssc_pkg::SSC_IDLE;
         act       <= '0;
         tmr_start <= 1'b0;
         tmr_load  <= 16'h0000;
         step      <= 3'h0;
         tick      <= 3'h0;
         line_idx  <= 12'h000;
         pix_idx   <= 12'h000;
         sum_idx   <= 8'h00;
      end
      else
      begin
         tmr_start <= 1'b0;
         case (state)
            ssc_pkg::SSC_IDLE:
               if (go)
               begin
                  act       <= cfg;
                  line_idx  <= 12'h000;
                  state     <= ssc_pkg::SSC_PRE_IMG;
                  tmr_start <= 1'b1;
                  tmr_load  <= ssc_pkg::SER_TO_IMG_CYC;
               end
            ssc_pkg::SSC_PRE_IMG:
               if (tmr_done)
               begin
                  state     <= ssc_pkg::SSC_IMG;
                  step      <= 3'h0;
                  tmr_start <= 1'b1;
                  tmr_load  <= ssc_pkg::IMG_OVERLAP_CYC;
               end
            ssc_pkg::SSC_IMG:
               if (tmr_done)
               begin
                  tmr_start <= 1'b1;
                  if (step == ssc_pkg::IMG_LAST)
                  begin
                     state    <= ssc_pkg::SSC_POST_IMG;
                     tmr_load <= ssc_pkg::IMG_TO_SER_CYC;
                  end
                  else
                  begin
                     step     <= step + 3'h1;
                     tmr_load <= ssc_pkg::IMG_OVERLAP_CYC;
                  end
               end
            ssc_pkg::SSC_POST_IMG:
               if (tmr_done)
               begin
                  if (line_idx < act.dump_lines)
                  begin
                     state     <= ssc_pkg::SSC_DUMP_PRE;
                     tmr_start <= 1'b1;
                     tmr_load  <= ssc_pkg::SER_TO_DUMP_CYC;
                  end
                  else
                  begin
                     state   <= ssc_pkg::SSC_READ;
                     tick    <= 3'h0;
                     pix_idx <= 12'h000;
                     sum_idx <= 8'h00;
                  end
               end
            ssc_pkg::SSC_DUMP_PRE:
               if (tmr_done)
               begin
                  state     <= ssc_pkg::SSC_DUMP_ON;
                  tmr_start <= 1'b1;
                  tmr_load  <= ssc_pkg::DUMP_WIDTH_CYC;
               end
            ssc_pkg::SSC_DUMP_ON:
               if (tmr_done)
               begin
                  state     <= ssc_pkg::SSC_DUMP_POST;
                  tmr_start <= 1'b1;
                  tmr_load  <= ssc_pkg::DUMP_TO_SER_CYC;
               end
            ssc_pkg::SSC_DUMP_POST:
               if (tmr_done)
               begin
                  // A dumped line is not read out
                  if (last_line)
                     state <= ssc_pkg::SSC_IDLE;
                  else
                  begin
                     line_idx  <= line_idx + 12'h001;
                     state     <= ssc_pkg::SSC_PRE_IMG;
                     tmr_start <= 1'b1;
                     tmr_load  <= ssc_pkg::SER_TO_IMG_CYC;
                  end
               end
            ssc_pkg::SSC_READ:
            begin
               tick <= tick + 3'h1;
               if (tick == ssc_pkg::PIX_LAST_TICK)
               begin
                  pix_idx <= pix_idx + 12'h001;
                  if (act.sum_count != 8'h00)
                     sum_idx <= (sum_idx == act.sum_count) ? 8'h00 : sum_idx + 8'h01;
                  if (last_pix)
                  begin
                     if (last_line)
                        state <= ssc_pkg::SSC_IDLE;
                     else
                     begin
                        line_idx  <= line_idx + 12'h001;
                        state     <= ssc_pkg::SSC_PRE_IMG;
                        tmr_start <= 1'b1;
                        tmr_load  <= ssc_pkg::SER_TO_IMG_CYC;
                     end
                  end
               end
            end
            default:
               state <= ssc_pkg::SSC_IDLE;
         endcase
      end
   end

   // Summing well level for the current tick
   always_comb
   begin
      if (act.mode2)
         sw_level = 1'b0;
      else if (state == ssc_pkg::SSC_READ && act.sum_count != 8'h00 && sum_idx < act.sum_count)
         sw_level = 1'b1;
      else
         sw_level = next_ph[2];
   end

   always_comb
   begin
      next_ph   = 3'b000;
      next_pins = '0;
      next_pins.image_phase = ssc_pkg::IMG_REST;
      case (state)
         ssc_pkg::SSC_PRE_IMG, ssc_pkg::SSC_POST_IMG:
            next_ph = 3'b011;
         ssc_pkg::SSC_IMG:
         begin
            next_ph = 3'b011;
            next_pins.image_phase = ssc_pkg::img_pattern(step);
         end
         ssc_pkg::SSC_DUMP_ON:
            next_pins.dump_gate = 1'b1;
         ssc_pkg::SSC_READ:
         begin
            // Short B pulse widens the A and C sampling windows
            next_ph = {ssc_pkg::SER_C_MASK[tick], ssc_pkg::SER_B_MASK[tick],
                       ssc_pkg::SER_A_MASK[tick]};
            // Mode 2 dumps charge on the B fall, so reset moves ahead of it
            next_pins.reset_pulse = act.mode2 ? ssc_pkg::RST_M2_MASK[tick]
                                              : ssc_pkg::RST_M1_MASK[tick];
         end
         default:
            next_ph = 3'b000;
      endcase
      next_pins.serial_elec       = next_elec;
      next_pins.summing_well_gate = {4{sw_level}};
      next_pins.output_gate       = act.mode2;
   end

   ssc_phase_map u_map (
      .ph   (next_ph),
      .dir  (act.dir),
      .elec (next_elec)
   );

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         // Image phases rest from reset on, so release shows no false image edge
         pins             <= '0;
         pins.image_phase <= ssc_pkg::IMG_REST;
         ph               <= 3'b000;
      end
      else
      begin
         pins <= next_pins;
         ph   <= next_ph;
      end
   end

   // Cycle distances between pin events, read only by the checks below
   logic [3:0]  img_prev;
   logic [11:0] ser_prev;
   logic        dg_prev;
   logic [15:0] img_quiet;
   logic [15:0] ser_quiet;
   logic [15:0] dg_quiet;
   logic [15:0] a_quiet;
   logic [15:0] lx_cnt;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         img_prev  <= ssc_pkg::IMG_REST;
         ser_prev  <= 12'h000;
         dg_prev   <= 1'b0;
         img_quiet <= 16'hffff;
         ser_quiet <= 16'hffff;
         dg_quiet  <= 16'hffff;
         a_quiet   <= 16'hffff;
         lx_cnt    <= 16'h0000;
      end
      else
      begin
         img_prev  <= pins.image_phase;
         ser_prev  <= pins.serial_elec;
         dg_prev   <= pins.dump_gate;
         img_quiet <= (pins.image_phase != img_prev) ? 16'h0001 : ssc_pkg::sat_inc(img_quiet);
         ser_quiet <= (pins.serial_elec != ser_prev) ? 16'h0001 : ssc_pkg::sat_inc(ser_quiet);
         dg_quiet  <= (pins.dump_gate != dg_prev) ? 16'h0001 : ssc_pkg::sat_inc(dg_quiet);
         a_quiet   <= (ph[0] && !ser_prev[0] && !act.dir[0]) ? 16'h0001
                      : ssc_pkg::sat_inc(a_quiet);
         lx_cnt    <= (state == ssc_pkg::SSC_PRE_IMG || state == ssc_pkg::SSC_IMG
                       || state == ssc_pkg::SSC_POST_IMG) ? ssc_pkg::sat_inc(lx_cnt) : 16'h0000;
      end
   end

   chk_img_overlap: assert property (@(posedge clk) disable iff (rst)
      (pins.image_phase != img_prev) |-> (img_quiet >= ssc_pkg::IMG_OVERLAP_CYC))
      else $error("image phase edges closer than the overlap time");

   chk_serial_to_image: assert property (@(posedge clk) disable iff (rst)
      ((pins.image_phase & ~img_prev) != 4'h0) |-> (ser_quiet >= ssc_pkg::SER_TO_IMG_CYC))
      else $error("image phase rose too soon after serial stop");

   chk_image_to_serial: assert property (@(posedge clk) disable iff (rst)
      (pins.serial_elec != ser_prev) |-> (img_quiet >= ssc_pkg::IMG_TO_SER_CYC))
      else $error("serial clocks restarted too soon after image fall");

   chk_dump_lead: assert property (@(posedge clk) disable iff (rst)
      (pins.dump_gate && !dg_prev) |-> (ser_quiet >= ssc_pkg::SER_TO_DUMP_CYC))
      else $error("dump gate rose too soon after serial fall");

   chk_dump_trail: assert property (@(posedge clk) disable iff (rst)
      ((pins.serial_elec & ~ser_prev) != 12'h000) |-> (dg_quiet >= ssc_pkg::DUMP_TO_SER_CYC))
      else $error("serial clock rose too soon after dump fall");

   chk_reset_width: assert property (@(posedge clk) disable iff (rst)
      $rose(pins.reset_pulse) |=> pins.reset_pulse ##1 !pins.reset_pulse)
      else $error("reset pulse not two cycles wide");

   chk_phase_overlap: assert property (@(posedge clk) disable iff (rst)
      (state == ssc_pkg::SSC_READ && $fell(ph[0])) |-> (ph[1] && $past(ph[1])))
      else $error("phase B does not overlap the fall of phase A");

   chk_ser_period: assert property (@(posedge clk) disable iff (rst)
      (ph[0] && !ser_prev[0] && !act.dir[0] && state == ssc_pkg::SSC_READ)
      |-> (a_quiet >= ssc_pkg::SER_PERIOD_CYC))
      else $error("serial period below minimum");

   chk_phase_route: assert property (@(posedge clk) disable iff (rst)
      (state != ssc_pkg::SSC_IDLE) |=> (pins.serial_elec[2:0] ==
         ($past(act.dir[0]) ? {ph[2], ph[0], ph[1]} : {ph[2], ph[1], ph[0]})))
      else $error("serial phases routed to wrong electrodes");

   chk_transfer_hold: assert property (@(posedge clk) disable iff (rst)
      (state == ssc_pkg::SSC_IMG) |=> ((pins.serial_elec & ssc_pkg::ELEC12_MASK)
                                       == ssc_pkg::ELEC12_MASK))
      else $error("electrodes 1 and 2 low during line transfer");

   chk_sw_follow: assert property (@(posedge clk) disable iff (rst)
      (state == ssc_pkg::SSC_READ && !act.mode2 && act.sum_count == 8'h00)
      |=> (pins.summing_well_gate == {4{ph[2]}}))
      else $error("summing well not following phase C");

   chk_mode2_gates: assert property (@(posedge clk) disable iff (rst)
      (state == ssc_pkg::SSC_READ && act.mode2)
      |=> (pins.output_gate && pins.summing_well_gate == 4'h0))
      else $error("mode 2 gate levels wrong");

   chk_line_time: assert property (@(posedge clk) disable iff (rst)
      (state == ssc_pkg::SSC_POST_IMG && tmr_done) |-> (lx_cnt >= ssc_pkg::LINE_XFER_CYC))
      else $error("line transfer shorter than minimum");

endmodule : ssc_sequencer
`default_nettype wire
